// File: rtl/dcwd_top.sv
// drive control word decoder with axi4-lite register slave
`include "dcwd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dcwd_top
   import dcwd_pkg::*;
#(
   parameter int unsigned RESP_CYCLES = `DCWD_RESP_TIME_NS / `DCWD_CLK_PERIOD_NS,
   parameter int unsigned NUM_EVENTS = `DCWD_NUM_EVENTS,
   parameter logic [NUM_EVENTS-1:0] FAULT_MASK = `DCWD_FAULT_MASK
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_EVENTS-1:0] event_set,
   input wire logic [NUM_EVENTS-1:0] event_cond,
   input wire logic [15:0] input_reg_value,
   output logic drive_run,
   output logic coast_stop,
   output logic quick_stop,
   output logic ramp_ready,
   output logic [1:0] stop_method,
   output logic [15:0] speed_ref,
   output logic event_reset_pulse,
   output logic [15:0] report_word,
   output logic [1:0] profile_active,
   output logic [15:0] coils,
   output logic [NUM_EVENTS-1:0] events
);

   // ****************************************
   // declarations
   // ****************************************
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic aw_held_r, w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   dcwd_word_type cw_raw_r, cw_acc_r, sp_raw_r, sp_acc_r, cfg_r, coils_r;
   dcwd_word_type speed_ref_r, report_word_r, report_nxt;
   logic word_stb_r;
   dcwd_profile_type profile_sel_r, profile_active_r, profile_nxt;
   dcwd_state_type state_r, state_nxt;
   logic drive_run_r, coast_stop_r, quick_stop_r, ramp_ready_r;
   logic [1:0] stop_method_r;
   logic [1:0] edge_rise;
   logic [NUM_EVENTS-1:0] ev_bank;
   logic [31:0] pend_cnt_r;

   function automatic logic [15:0] dcwd_merge(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      dcwd_merge = old;
      if (strb[0])
         dcwd_merge[7:0] = data[7:0];
      if (strb[1])
         dcwd_merge[15:8] = data[15:8];
   endfunction : dcwd_merge

   // ****************************************
   // bus handshakes and decode
   // ****************************************
   wire aw_hs = s_axi_awvalid & awready_r;
   wire w_hs = s_axi_wvalid & wready_r;
   wire b_hs = bvalid_r & s_axi_bready;
   wire ar_hs = s_axi_arvalid & arready_r;
   wire r_hs = rvalid_r & s_axi_rready;
   // answer only to a complete request
   wire do_write = aw_held_r & w_held_r & ~bvalid_r;
   wire grid_mode = cfg_r[`DCWD_CFG_GRID];
   wire fb_place = cfg_r[`DCWD_CFG_FIELDBUS];
   wire [1:0] msr_cfg = cfg_r[`DCWD_CFG_MSR_HI:`DCWD_CFG_MSR_LO];
   wire wr_cmd = do_write & (awaddr_r == `DCWD_OFS_CMD);
   wire wr_prof = do_write & (awaddr_r == `DCWD_OFS_PROFILE);
   wire wr_sp = do_write & (awaddr_r == `DCWD_OFS_SETPOINT);
   wire wr_cfg = do_write & (awaddr_r == `DCWD_OFS_CONFIG);
   wire wr_coil = do_write & (awaddr_r == `DCWD_OFS_COILS);
   wire [15:0] prof_word = dcwd_merge({14'h0000, profile_sel_r}, wdata_r, wstrb_r);
   wire prof_reject = wr_prof & grid_mode & (prof_word[1:0] != `DCWD_PROF_HYBRID);
   // input register and status words refuse writes
   wire wr_err = do_write & ~((wr_cmd | wr_prof | wr_sp | wr_cfg | wr_coil) & ~prof_reject);
   wire rd_cmd = s_axi_araddr == `DCWD_OFS_CMD;
   wire rd_prof = s_axi_araddr == `DCWD_OFS_PROFILE;
   wire rd_sp = s_axi_araddr == `DCWD_OFS_SETPOINT;
   wire rd_cfg = s_axi_araddr == `DCWD_OFS_CONFIG;
   wire rd_stat = s_axi_araddr == `DCWD_OFS_STATUS;
   wire rd_ref = s_axi_araddr == `DCWD_OFS_SPEEDREF;
   wire rd_ev = s_axi_araddr == `DCWD_OFS_EVENTS;
   wire rd_coil = s_axi_araddr == `DCWD_OFS_COILS;
   wire rd_in = s_axi_araddr == `DCWD_OFS_INREG;
   wire rd_hit = rd_cmd | rd_prof | rd_sp | rd_cfg | rd_stat | rd_ref | rd_ev | rd_coil | rd_in;
   wire [31:0] rd_data = rd_cmd ? {16'h0000, cw_raw_r} :
                         rd_prof ? {30'h00000000, profile_sel_r} :
                         rd_sp ? {16'h0000, sp_raw_r} :
                         rd_cfg ? {16'h0000, cfg_r} :
                         rd_stat ? {12'h000, state_r, profile_active_r, report_word_r} :
                         rd_ref ? {16'h0000, speed_ref_r} :
                         rd_ev ? 32'(ev_bank) :
                         rd_coil ? {16'h0000, coils_r} :
                         rd_in ? {16'h0000, input_reg_value} : 32'h00000000;

   // ****************************************
   // write channel
   // ****************************************
   // one write in flight, ready drops until the response is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `DCWD_RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         if (w_hs)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         if (do_write)
         begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_err ? `DCWD_RESP_SLVERR : `DCWD_RESP_OKAY;
         end
         if (b_hs)
         begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `DCWD_RESP_OKAY;
      end
      else
      begin
         if (ar_hs)
         begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_hit ? `DCWD_RESP_OKAY : `DCWD_RESP_SLVERR;
         end
         if (r_hs)
         begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cw_raw_r <= `DCWD_RST_WORD;
         word_stb_r <= 1'b0;
         sp_raw_r <= `DCWD_RST_WORD;
         cfg_r <= `DCWD_RST_CFG;
         coils_r <= `DCWD_RST_WORD;
         profile_sel_r <= `DCWD_PROF_GENERIC;
      end
      else
      begin
         word_stb_r <= wr_cmd;
         if (wr_cmd)
            cw_raw_r <= dcwd_merge(cw_raw_r, wdata_r, wstrb_r);
         if (wr_sp)
            sp_raw_r <= dcwd_merge(sp_raw_r, wdata_r, wstrb_r);
         if (wr_cfg)
            cfg_r <= dcwd_merge(cfg_r, wdata_r, wstrb_r);
         if (wr_coil)
            coils_r <= dcwd_merge(coils_r, wdata_r, wstrb_r);
         if (wr_prof & ~prof_reject)
            profile_sel_r <= prof_word[1:0];
      end
   end

   // ****************************************
   // accepted process data
   // ****************************************
   // data valid gates acceptance
   wire accept = word_stb_r & cw_raw_r[`DCWD_CW_VALID];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cw_acc_r <= `DCWD_RST_WORD;
         sp_acc_r <= `DCWD_RST_WORD;
      end
      else if (accept)
      begin
         cw_acc_r <= cw_raw_r;
         sp_acc_r <= sp_raw_r;
      end
   end

   dcwd_edge #(
      .W(2)
   ) u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample(accept),
      .bits({cw_raw_r[`DCWD_CW_RESET], cw_raw_r[`DCWD_CW_START]}),
      .rise(edge_rise)
   );

   // events with cond_in low cleared by reset edge
   dcwd_events #(
      .N(NUM_EVENTS)
   ) u_events (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_in(event_set),
      .cond_in(event_cond),
      .clear(edge_rise[1]),
      .ev(ev_bank)
   );

   // ****************************************
   // drive state
   // ****************************************
   // only decoded bits are read; reserved ones never appear
   wire coast_ok = cw_acc_r[`DCWD_CW_COAST];
   wire quick_ok = cw_acc_r[`DCWD_CW_QUICK];
   wire start_lvl = cw_acc_r[`DCWD_CW_START];
   wire fault_any = |(ev_bank & FAULT_MASK);
   wire start_ok = coast_ok & quick_ok & fb_place;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         // acknowledge with bit 0 low once faults are gone
         st_inhibit:
            if (!fault_any && !cw_acc_r[`DCWD_CW_RAMP])
               state_nxt = st_ready;
         // edge, not level, starts the drive
         st_ready:
            if (fault_any)
               state_nxt = st_inhibit;
            else if (edge_rise[0] && start_ok)
               state_nxt = st_run;
         st_run:
            if (fault_any)
               state_nxt = st_inhibit;
            else if (!coast_ok || !quick_ok || !start_lvl)
               state_nxt = st_ready;
      endcase
   end

   // profile forced to hybrid in grid mode, else held while fieldbus does not command a motor
   assign profile_nxt = grid_mode ? `DCWD_PROF_HYBRID :
                        fb_place ? profile_sel_r : profile_active_r;

   always_comb
   begin
      report_nxt = `DCWD_RST_WORD;
      report_nxt[`DCWD_RW_READY] = (state_r == st_ready) & coast_ok & quick_ok;
      report_nxt[`DCWD_RW_RUN] = state_r == st_run;
      report_nxt[`DCWD_RW_FAULT] = fault_any;
      report_nxt[`DCWD_RW_QSTOP] = ~quick_ok;
      report_nxt[`DCWD_RW_WDOG] = cw_raw_r[`DCWD_CW_WDOG];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r <= st_inhibit;
         drive_run_r <= 1'b0;
         coast_stop_r <= 1'b1;
         quick_stop_r <= 1'b1;
         ramp_ready_r <= 1'b0;
         stop_method_r <= 2'h0;
         speed_ref_r <= `DCWD_RST_WORD;
         report_word_r <= `DCWD_RST_WORD;
         profile_active_r <= `DCWD_PROF_GENERIC;
      end
      else
      begin
         state_r <= state_nxt;
         drive_run_r <= state_nxt == st_run;
         coast_stop_r <= ~coast_ok | fault_any;
         quick_stop_r <= ~quick_ok;
         ramp_ready_r <= cw_acc_r[`DCWD_CW_RAMP];
         if (state_r == st_run && !start_lvl)
            stop_method_r <= msr_cfg;
         // sign inversion; a negative setpoint reversed turns forward
         speed_ref_r <= cw_acc_r[`DCWD_CW_REVERSE] ? 16'(`DCWD_RST_WORD - sp_acc_r) : sp_acc_r;
         report_word_r <= report_nxt;
         profile_active_r <= profile_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign drive_run = drive_run_r;
   assign coast_stop = coast_stop_r;
   assign quick_stop = quick_stop_r;
   assign ramp_ready = ramp_ready_r;
   assign stop_method = stop_method_r;
   assign speed_ref = speed_ref_r;
   assign event_reset_pulse = edge_rise[1];
   assign report_word = report_word_r;
   assign profile_active = profile_active_r;
   assign coils = coils_r;
   assign events = ev_bank;

   // ****************************************
   // checks
   // ****************************************
   // helper: cycles a complete write request waits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pend_cnt_r <= 32'h00000000;
      else
         pend_cnt_r <= (aw_held_r & w_held_r & ~bvalid_r) ? pend_cnt_r + 32'h00000001 : 32'h00000000;
   end

   property p_start_edge;
      @(posedge aclk) disable iff (!aresetn)
      state_r == st_ready && !fault_any && edge_rise[0] && start_ok |=> drive_run_r && state_r == st_run;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start edge did not run the drive");

   property p_no_level_start;
      @(posedge aclk) disable iff (!aresetn)
      state_r == st_ready && !edge_rise[0] |=> !drive_run_r;
   endproperty
   a_no_level_start: assert property (p_no_level_start) else $error("drive started without edge");

   property p_coast;
      @(posedge aclk) disable iff (!aresetn)
      state_r == st_run && !coast_ok |=> !drive_run_r && coast_stop_r;
   endproperty
   a_coast: assert property (p_coast) else $error("coast request did not stop the drive");

   property p_quick;
      @(posedge aclk) disable iff (!aresetn)
      state_r == st_run && !quick_ok |=> !drive_run_r && quick_stop_r;
   endproperty
   a_quick: assert property (p_quick) else $error("quick stop not applied");

   property p_stop_method;
      @(posedge aclk) disable iff (!aresetn)
      state_r == st_run && !start_lvl |=> !drive_run_r && stop_method_r == $past(msr_cfg);
   endproperty
   a_stop_method: assert property (p_stop_method) else $error("wrong stop method");

   property p_inhibit;
      @(posedge aclk) disable iff (!aresetn)
      fault_any |=> state_r == st_inhibit ##1 !drive_run_r;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("fault did not inhibit switching on");

   property p_reverse;
      @(posedge aclk) disable iff (!aresetn)
      accept |=> ##1 speed_ref_r == ($past(cw_raw_r[`DCWD_CW_REVERSE], 2) ?
                  16'(`DCWD_RST_WORD - $past(sp_raw_r, 2)) : $past(sp_raw_r, 2));
   endproperty
   a_reverse: assert property (p_reverse) else $error("speed reference sign wrong");

   property p_data_hold;
      @(posedge aclk) disable iff (!aresetn)
      word_stb_r && !cw_raw_r[`DCWD_CW_VALID] |=> $stable(cw_acc_r) && $stable(sp_acc_r);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("invalid process data accepted");

   property p_watchdog;
      @(posedge aclk) disable iff (!aresetn)
      wr_cmd && wstrb_r[1] |=> ##1 report_word_r[`DCWD_RW_WDOG] == $past(wdata_r[`DCWD_CW_WDOG], 2);
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog not echoed");

   property p_grid_reject;
      @(posedge aclk) disable iff (!aresetn)
      prof_reject |=> $stable(profile_sel_r) && bvalid_r && bresp_r == `DCWD_RESP_SLVERR;
   endproperty
   a_grid_reject: assert property (p_grid_reject) else $error("non-hybrid profile taken in grid mode");

   property p_inreg_ro;
      @(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_r == `DCWD_OFS_INREG |=> bvalid_r && bresp_r == `DCWD_RESP_SLVERR;
   endproperty
   a_inreg_ro: assert property (p_inreg_ro) else $error("input register write not refused");

   property p_resp_time;
      @(posedge aclk) disable iff (!aresetn)
      pend_cnt_r < RESP_CYCLES;
   endproperty
   a_resp_time: assert property (p_resp_time) else $error("write answer too late");

   property p_one_write;
      @(posedge aclk) disable iff (!aresetn)
      bvalid_r |-> !awready_r && !wready_r;
   endproperty
   a_one_write: assert property (p_one_write) else $error("second write taken while one open");

   property p_no_unsolicited;
      @(posedge aclk) disable iff (!aresetn)
      !bvalid_r && !(aw_held_r && w_held_r) |=> !bvalid_r;
   endproperty
   a_no_unsolicited: assert property (p_no_unsolicited) else $error("response without request");

endmodule : dcwd_top
`default_nettype wire

// File: pkg/dcwd_cfg.svh
// constants of the drive control word decoder
`ifndef DCWD_CFG_SVH
`define DCWD_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define DCWD_ADDR_W 8
`define DCWD_OFS_CMD 8'h00
// holding location 1, four bytes per word
`define DCWD_OFS_PROFILE 8'h04
`define DCWD_OFS_SETPOINT 8'h08
`define DCWD_OFS_CONFIG 8'h0c
`define DCWD_OFS_STATUS 8'h10
`define DCWD_OFS_SPEEDREF 8'h14
`define DCWD_OFS_EVENTS 8'h18
`define DCWD_OFS_COILS 8'h1c
`define DCWD_OFS_INREG 8'h20

// ****************************************
// command word and report word bits
// ****************************************
`define DCWD_CW_RAMP 0
`define DCWD_CW_COAST 1
`define DCWD_CW_QUICK 2
`define DCWD_CW_START 3
`define DCWD_CW_RESET 7
`define DCWD_CW_REVERSE 8
`define DCWD_CW_VALID 10
`define DCWD_CW_WDOG 11
`define DCWD_RW_READY 0
`define DCWD_RW_RUN 2
`define DCWD_RW_FAULT 3
`define DCWD_RW_QSTOP 5
`define DCWD_RW_WDOG 11

// ****************************************
// configuration fields, profiles, resets
// ****************************************
`define DCWD_CFG_FIELDBUS 0
`define DCWD_CFG_GRID 1
`define DCWD_CFG_MSR_LO 4
`define DCWD_CFG_MSR_HI 5
`define DCWD_PROF_GENERIC 2'h0
`define DCWD_PROF_SPEED 2'h1
`define DCWD_PROF_HYBRID 2'h2
`define DCWD_PROF_CLASS1 2'h3
`define DCWD_RST_WORD 16'h0000
`define DCWD_RST_CFG 16'h0001
`define DCWD_RESP_OKAY 2'h0
`define DCWD_RESP_SLVERR 2'h2

// ****************************************
// timing and events
// ****************************************
`define DCWD_RESP_TIME_NS 5000000
`define DCWD_CLK_PERIOD_NS 5
`define DCWD_NUM_EVENTS 8
`define DCWD_FAULT_MASK 8'hf0

`endif

// File: pkg/dcwd_pkg.sv
// types of the drive control word decoder
`default_nettype none
package dcwd_pkg;
   typedef logic [15:0] dcwd_word_type;
   typedef logic [1:0] dcwd_profile_type;
   typedef enum logic [1:0] {st_inhibit, st_ready, st_run} dcwd_state_type;
endpackage : dcwd_pkg
`default_nettype wire

// File: rtl/dcwd_edge.sv
// rising edge detector for sampled control bits
`timescale 1ns/1ps
`default_nettype none
module dcwd_edge #(
   parameter int unsigned W = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sample,
   input wire logic [W-1:0] bits,
   output logic [W-1:0] rise
);
   logic [W-1:0] prev_r;
   logic [W-1:0] rise_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_r <= '0;
         rise_r <= '0;
      end
      else
      begin
         rise_r <= sample ? (bits & ~prev_r) : '0;
         if (sample)
            prev_r <= bits;
      end
   end

   assign rise = rise_r;
endmodule : dcwd_edge
`default_nettype wire

// File: rtl/dcwd_events.sv
// sticky event bank with conditional clear
`timescale 1ns/1ps
`default_nettype none
module dcwd_events #(
   parameter int unsigned N = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] set_in,
   input wire logic [N-1:0] cond_in,
   input wire logic clear,
   output logic [N-1:0] ev
);
   logic [N-1:0] ev_r;
   logic [N-1:0] keep;

   assign keep = clear ? (ev_r & cond_in) : ev_r;

   // set wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ev_r <= '0;
      else
         ev_r <= keep | set_in;
   end

   assign ev = ev_r;
endmodule : dcwd_events
`default_nettype wire

// File: bench/dcwd_client.sv
// axi4-lite client model that starts every register transfer
`timescale 1ns/1ps
`default_nettype none
module dcwd_client (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
   initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do
      begin
         @(posedge aclk);
         n++;
         // released lines show the inverse, not a stale value
         if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end while (!s_axi_bvalid && n < 40);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) dcwd_top_tb.test_done(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end while (!s_axi_rvalid && n < 40);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n == 40) dcwd_top_tb.test_done(1);
   endtask : rd
endmodule : dcwd_client
`default_nettype wire

// File: bench/dcwd_top_tb.sv
// self-checking bench of the drive control word decoder
`timescale 1ns/1ps
`default_nettype none
module dcwd_top_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr, events, event_set = 8'h00, event_cond = 8'h00;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, drive_run, coast_stop, quick_stop;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, r;
   logic [15:0] speed_ref, report_word, coils, inreg = 16'h1234;
   logic [1:0] s_axi_rresp, stop_method, profile_active;
   logic [3:0] wstrb = 4'hf;
   logic ramp_ready, event_reset_pulse;
   int pulse_cnt = 0;
   int err_total = 0;
   int samples_checked = 0;
   always #2.5 aclk = ~aclk;
   // counts cycles the reset pulse stands, so a pulse longer than one cycle shows up
   always @(posedge aclk) pulse_cnt <= pulse_cnt + int'(event_reset_pulse);
   // short response count tightens the write answer time check
   dcwd_top #(.RESP_CYCLES(16)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_set, .event_cond, .input_reg_value(inreg),
      .drive_run, .coast_stop, .quick_stop, .ramp_ready, .stop_method, .speed_ref, .event_reset_pulse,
      .report_word, .profile_active, .coils, .events);
   dcwd_client client (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
   task automatic test_done(input bit hung);
      if (hung) err_total++;
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wx(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      client.wr(a, v, r);
      chk(32'(r), 32'(er));
   endtask : wx
   task automatic rx(input logic [7:0] a, input logic [31:0] e);
      client.rd(a, d);
      chk(d, e);
   endtask : rx
   // outputs settle three edges after the word lands
   task automatic cmd(input logic [15:0] w);
      wx(8'h00, 32'(w), 2'h0);
      repeat (4) @(posedge aclk);
   endtask : cmd
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rx(8'h0c, 32'h1);
      // fieldbus place kept, missing-start response 2
      wx(8'h0c, 32'h21, 2'h0);
      wx(8'h08, 32'h5, 2'h0);
      cmd(16'h0506);
      chk(32'(speed_ref), 32'hfffb);
      chk(32'({coast_stop, quick_stop, ramp_ready}), 32'h0);
      wx(8'h08, 32'hfffb, 2'h0);
      cmd(16'h0506);
      chk(32'(speed_ref), 32'h5);
      cmd(16'h040e);
      chk(32'(drive_run), 32'h1);
      cmd(16'h0407);
      chk(32'({drive_run, ramp_ready, stop_method}), 32'h6);
      cmd(16'h067e);
      chk(32'(drive_run), 32'h1);
      cmd(16'h000a);
      chk(32'(drive_run), 32'h1);
      cmd(16'h040a);
      chk(32'({drive_run, coast_stop, quick_stop}), 32'h1);
      cmd(16'h040e);
      chk(32'(drive_run), 32'h0);
      cmd(16'h0800);
      chk(32'(report_word[11]), 32'h1);
      event_cond <= 8'h03;
      event_set <= 8'h03;
      @(posedge aclk);
      event_set <= 8'h00;
      cmd(16'h0480);
      chk(32'(events), 32'h3);
      event_cond <= 8'h01;
      cmd(16'h0400);
      cmd(16'h0480);
      chk(32'(events), 32'h1);
      // a fault event inhibits until cleared and acknowledged with bit 0 low
      event_set <= 8'h10;
      @(posedge aclk);
      event_set <= 8'h00;
      cmd(16'h0407);
      chk(32'(report_word[3:0]), 32'h8);
      cmd(16'h0487);
      chk(32'({events, report_word[3:0]}), 32'h10);
      cmd(16'h0406);
      chk(32'(report_word[3:0]), 32'h1);
      wx(8'h20, 32'h1, 2'h2);
      rx(8'h20, 32'h1234);
      inreg <= 16'h5a5a;
      rx(8'h20, 32'h5a5a);
      wx(8'h1c, 32'h1, 2'h0);
      rx(8'h1c, 32'h1);
      chk(32'(coils), 32'h1);
      // low byte lane only: upper coils keep their value
      wstrb <= 4'h1;
      wx(8'h1c, 32'hffff, 2'h0);
      wstrb <= 4'hf;
      rx(8'h1c, 32'hff);
      wx(8'h04, 32'h1, 2'h0);
      rx(8'h04, 32'h1);
      chk(32'(profile_active), 32'h1);
      wx(8'h0c, 32'h3, 2'h0);
      wx(8'h04, 32'h1, 2'h2);
      rx(8'h04, 32'h1);
      chk(32'(profile_active), 32'h2);
      rx(8'h44, 32'h0);
      chk(32'({s_axi_rresp, pulse_cnt[3:0]}), 32'h23);
      test_done(0);
   end
endmodule : dcwd_top_tb
`default_nettype wire
